/* File: flash_addr_consts.svh */
`ifndef FLASH_ADDR_CONSTS_SVH
`define FLASH_ADDR_CONSTS_SVH

// ****************************************
// Opcodes
// ****************************************
`define OP_BANK_READ      8'h16
`define OP_BANK_WRITE     8'h17
`define OP_SOFT_RESET     8'hf0
`define OP_CFG_DETECT     8'h07
`define OP_READ4_FIXED    8'h13
`define OP_READ_BANKED    8'h03

// ****************************************
// Bank register layout and reset value
// ****************************************
`define BANK_EXT_BIT      7
`define BANK_RESET        8'h00

// ****************************************
// Parameter table window and contents
// ****************************************
`define PT_BASE           8'h3c
`define PT_LEN            12
`define PT_DW16           32'ha8fa28f0
`define PT_MAP_DW1        32'h803007fc
`define PT_MAP_DW2        32'hffffffff
`define ERASE_OPT_MASK    8'h80

`endif

/* File: flash_addr_pkg.sv */
package flash_addr_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR   = 3'b001,
    ST_WDATA  = 3'b010,
    ST_RDATA  = 3'b011,
    ST_IGNORE = 3'b100
  } phase_type;
endpackage

/* File: sync2.sv */
`timescale 1ns/100ps
// ****************************************
// Two-stage level synchroniser
// ****************************************
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

/* File: flash_addr_mode_and_detect.sv */
`timescale 1ns/100ps
`include "flash_addr_consts.svh"
// Functional notes
// RQ1: Bank bit 7 set selects 4-byte addresses; bank upper bits ignored.
// RQ2: Opcode 16h reads the bank register, 17h writes one byte.
// RQ3: Bank bit 7 clear: 3-byte addresses, bank bits pick 128 Mb segment.
// RQ4: Hardware reset returns the device to 3-byte addressing.
// RQ5: Opcode F0h alone performs a soft reset.
// RQ6: Host exits 0-4-4 continuous read before other resets.
// RQ7: Dedicated 4-byte address opcode works regardless of bank mode.
// RQ8: Opcode 07h reads status register 2 with no address phase.
// RQ9: Detection byte follows the opcode with zero dummy cycles.
// RQ10: Host masks detection byte with 80h; bit 7 is erase option.
// RQ11: First detection descriptor is a command descriptor, not the end.
// RQ12: Parameter table bytes are fixed constants, unaffected by anything.
module flash_addr_mode_and_detect #(
  parameter int AW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          sck,
  input  wire logic          cs_n,
  input  wire logic          si,
  output logic               so,
  output logic               so_oe_n,
  input  wire logic [7:0]    status2,
  input  wire logic [7:0]    table_index,
  output logic      [7:0]    table_byte,
  output logic      [AW-1:0] mem_addr,
  output logic               mem_addr_valid,
  output logic               soft_reset,
  output logic               addr4_mode
);
  // ****************************************
  // Pin synchronisation and edge detect
  // ****************************************
  logic [2:0] pins_s;
  logic       sck_prev_q;
  logic       cs_prev_q;
  // Select goes in inverted: a cleared stage then reads as deselected,
  // so no false frame end follows reset
  sync2 #(.W(3)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({sck, ~cs_n, si}),
    .dout (pins_s)
  );
  wire sck_s  = pins_s[2];
  wire cs_s   = ~pins_s[1];
  wire si_s   = pins_s[0];
  wire rise   = sck_s & ~sck_prev_q & ~cs_s;
  wire fall   = ~sck_s & sck_prev_q & ~cs_s;
  wire cs_end = cs_s & ~cs_prev_q;

  // Edge history; sample sync outputs only
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
    end
  end

  // ****************************************
  // Command shifter and phase machine
  // ****************************************
  flash_addr_pkg::phase_type phase_q;
  logic [7:0]  shift_q;
  logic [2:0]  bit_q;
  logic [7:0]  opcode_q;
  logic [AW-1:0] addr_q;
  logic [5:0]  abits_q;
  logic [7:0]  bank_q;
  logic [7:0]  tx_q;
  logic        so_q;
  logic        oe_n_q;
  logic        srst_q;
  logic        aval_q;
  wire  [7:0]  shift_next = {shift_q[6:0], si_s};
  wire         byte_done  = rise & (bit_q == 3'd7);
  wire         ext_mode   = bank_q[`BANK_EXT_BIT];
  // Address length depends on the opcode and mode
  wire         four_byte  = ext_mode | (opcode_q == `OP_READ4_FIXED);
  wire  [5:0]  addr_len   = four_byte ? 6'd32 : 6'd24;

  // Bit counter restarts at every frame
  always_ff @(posedge clk) begin
    if (rst || cs_s) begin
      bit_q   <= 3'd0;
      shift_q <= 8'h00;
    end else if (rise) begin
      bit_q   <= bit_q + 3'd1;
      shift_q <= shift_next;
    end
  end

  // Opcode decode and phase stepping
  always_ff @(posedge clk) begin
    if (rst || cs_s) begin
      phase_q  <= flash_addr_pkg::ST_OPCODE;
      opcode_q <= 8'h00;
    end else if (byte_done) begin
      case (phase_q)
        flash_addr_pkg::ST_OPCODE: begin
          opcode_q <= shift_next;
          case (shift_next)
            `OP_BANK_READ:   phase_q <= flash_addr_pkg::ST_RDATA; // [RQ2]
            `OP_BANK_WRITE:  phase_q <= flash_addr_pkg::ST_WDATA; // [RQ2]
            `OP_CFG_DETECT:  phase_q <= flash_addr_pkg::ST_RDATA; // [RQ8]
            `OP_READ4_FIXED: phase_q <= flash_addr_pkg::ST_ADDR;  // [RQ7]
            `OP_READ_BANKED: phase_q <= flash_addr_pkg::ST_ADDR;  // [RQ3]
            default:         phase_q <= flash_addr_pkg::ST_IGNORE;
          endcase
        end
        flash_addr_pkg::ST_WDATA: phase_q <= flash_addr_pkg::ST_IGNORE;
        default:                  phase_q <= phase_q;
      endcase
    end
  end

  // Address capture; read data is beyond this block
  always_ff @(posedge clk) begin
    if (rst || cs_s) begin
      addr_q  <= '0;
      abits_q <= 6'd0;
      aval_q  <= 1'b0;
    end else if (rise && phase_q == flash_addr_pkg::ST_ADDR &&
                 abits_q < addr_len) begin
      addr_q  <= {addr_q[AW-2:0], si_s};
      abits_q <= abits_q + 6'd1;
      aval_q  <= (abits_q == addr_len - 6'd1);
    end else begin
      aval_q  <= 1'b0;
    end
  end

  // Effective address: bank supplies upper bits only in 3-byte mode
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr <= '0;
    end else if (aval_q) begin
      if (four_byte) begin
        mem_addr <= addr_q; // [RQ1] [RQ7]
      end else begin
        mem_addr <= {1'b0, bank_q[6:0], addr_q[23:0]}; // [RQ3]
      end
    end
  end

  // Bank register: cleared by hardware and soft reset
  always_ff @(posedge clk) begin
    if (rst || srst_q) begin
      bank_q <= `BANK_RESET; // [RQ4] [RQ5]
    end else if (byte_done && phase_q == flash_addr_pkg::ST_WDATA &&
                 opcode_q == `OP_BANK_WRITE) begin
      bank_q <= shift_next; // [RQ2]
    end
  end

  // Soft reset pulse at frame end after an F0h opcode, whatever bytes follow it
  always_ff @(posedge clk) begin
    if (rst) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= cs_end && opcode_q == `OP_SOFT_RESET &&
                phase_q == flash_addr_pkg::ST_IGNORE; // [RQ5]
    end
  end

  // Output shifter: first data bit on the fall after opcode, no dummy
  always_ff @(posedge clk) begin
    if (rst || cs_s) begin
      tx_q   <= 8'h00;
      so_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (fall && phase_q == flash_addr_pkg::ST_RDATA) begin
      if (bit_q == 3'd0) begin
        // Status 2 is sampled fresh at each byte boundary
        if (opcode_q == `OP_CFG_DETECT) begin
          so_q <= status2[7]; // [RQ9]
          tx_q <= {status2[6:0], 1'b0};
        end else begin
          so_q <= bank_q[7]; // [RQ2]
          tx_q <= {bank_q[6:0], 1'b0};
        end
      end else begin
        so_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
      oe_n_q <= 1'b0;
    end
  end

  // ****************************************
  // Fixed parameter table
  // ****************************************
  logic [7:0] pt_off;
  logic [7:0] pt_byte;
  logic [31:0] pt_word;
  always_comb begin
    pt_off  = table_index - `PT_BASE;
    pt_word = 32'hffffffff;
    case (pt_off[3:2])
      2'd0:    pt_word = `PT_DW16;
      2'd1:    pt_word = `PT_MAP_DW1; // [RQ11]
      2'd2:    pt_word = `PT_MAP_DW2;
      default: pt_word = 32'hffffffff;
    endcase
    pt_byte = pt_word[pt_off[1:0]*8 +: 8];
  end

  // Registered lookup; no write path exists into it
  always_ff @(posedge clk) begin
    if (rst) begin
      table_byte <= 8'hff;
    end else if (table_index >= `PT_BASE &&
                 table_index < `PT_BASE + 8'(`PT_LEN)) begin
      table_byte <= pt_byte; // [RQ12]
    end else begin
      table_byte <= 8'hff;
    end
  end

  assign so             = so_q;
  assign so_oe_n        = oe_n_q;
  assign soft_reset     = srst_q;
  assign mem_addr_valid = aval_q;
  assign addr4_mode     = ext_mode;

  // ****************************************
  // Checks
  // ****************************************
  chk_bank_reset: assert property (@(posedge clk) // [RQ4]
    rst |=> bank_q == 8'h00) else $error("bank not cleared by reset");
  chk_soft_clear: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    srst_q |=> bank_q == 8'h00) else $error("soft reset kept bank");
  chk_ext_addr: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    aval_q && ext_mode |=> mem_addr == $past(addr_q))
    else $error("4-byte address wrong");
  chk_seg_addr: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    aval_q && !four_byte |=> mem_addr[30:24] == $past(bank_q[6:0]))
    else $error("segment bits wrong");
  chk_seg_low: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    aval_q && !four_byte |=>
    mem_addr[31] == 1'b0 && mem_addr[23:0] == $past(addr_q[23:0]))
    else $error("3-byte address wrong");
  chk_detect_nodummy: assert property (@(posedge clk) // [RQ9]
    disable iff (rst)
    fall && phase_q == flash_addr_pkg::ST_RDATA && bit_q == 3'd0 &&
    opcode_q == `OP_CFG_DETECT |=> so == $past(status2[7]))
    else $error("detect byte delayed");
  chk_table_const: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    table_index == 8'h40 |=> table_byte == 8'hfc)
    else $error("descriptor byte changed");
  chk_wr_bank: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    byte_done && phase_q == flash_addr_pkg::ST_WDATA && !srst_q
    |=> bank_q == $past(shift_next)) else $error("bank write lost");
endmodule

/* File: spi_host_model.sv */
`timescale 1ns/100ps
// ****
// Host side of the serial link, mode 0
// ****
module spi_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  // Parked clock, deselected; never enters continuous read
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // Eight cycles a half keeps margin over the pin synchroniser
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  // Byte out and in, MSB first, sampled on the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      half();
      sck <= 1'b1;
      rx[i] = so;
      half();
      sck <= 1'b0;
    end
  endtask
  // Frame start
  task automatic open_f();
    @(posedge clk);
    cs_n <= 1'b0;
    half();
  endtask
  // Frame end; data line flips so no stale level is left
  task automatic close_f();
    half();
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (16) @(posedge clk);
  endtask
endmodule

/* File: tb_flash_addr_mode_and_detect.sv */
`timescale 1ns/100ps
module tb_flash_addr_mode_and_detect;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sck, cs_n, si, so, so_oe_n, mem_addr_valid;
  logic        soft_reset, addr4_mode;
  logic        v_q = 1'b0;
  logic [7:0]  status2 = 8'h00;
  logic [7:0]  table_index = 8'h00;
  logic [7:0]  table_byte, rx;
  logic [31:0] mem_addr, got_addr;
  int          miscompares = 0;
  int          n_compared = 0;
  int          n_soft = 0;
  logic [7:0]  tbl [12] = '{8'hf0, 8'h28, 8'hfa, 8'ha8, 8'hfc, 8'h07,
                            8'h30, 8'h80, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0]  bv [4] = '{8'h05, 8'h7f, 8'h85, 8'hff};
  logic [7:0]  sv [3] = '{8'h80, 8'h7f, 8'ha5};
  logic [31:0] ad = 32'hc3a5_5a0f;

  // 20 MHz clock
  always #25 clk = ~clk;

  flash_addr_mode_and_detect u_dut (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .status2(status2), .table_index(table_index),
    .table_byte(table_byte), .mem_addr(mem_addr),
    .mem_addr_valid(mem_addr_valid), .soft_reset(soft_reset),
    .addr4_mode(addr4_mode));
  spi_host_model u_host (
    .clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so));

  // Address taken one cycle after its strobe; reset pulses counted
  always @(posedge clk) begin
    v_q <= mem_addr_valid;
    if (v_q === 1'b1) got_addr <= mem_addr;
    if (soft_reset === 1'b1) n_soft <= n_soft + 1;
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bank_wr(input logic [7:0] v);
    u_host.open_f();
    u_host.xfer(8'h17, rx);
    u_host.xfer(v, rx);
    u_host.close_f();
  endtask
  // Opcode, then one byte back with no dummy cycles
  task automatic cmd_rd(input logic [7:0] op, output logic [7:0] v);
    u_host.open_f();
    u_host.xfer(op, v);
    u_host.xfer(8'h00, v);
    chk(so_oe_n, 1'b0, "so_oe_n");
    u_host.close_f();
  endtask
  // Whole table window plus two bytes either side
  task automatic tbl_chk();
    for (int i = 8'h3a; i < 8'h4a; i++) begin
      table_index <= i[7:0];
      repeat (2) @(posedge clk);
      chk(table_byte, (i < 8'h3c || i > 8'h47) ? 8'hff : tbl[i - 8'h3c],
          "table_byte");
    end
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (6) @(posedge clk);
    chk(addr4_mode, 1'b0, "addr4_mode");
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    tbl_chk();
    foreach (bv[k]) begin
      bank_wr(bv[k]);
      cmd_rd(8'h16, rx);
      chk(rx, bv[k], "bank");
      chk(addr4_mode, bv[k][7], "addr4_mode");
      u_host.open_f();
      u_host.xfer(8'h13, rx);
      for (int j = 3; j >= 0; j--) u_host.xfer(ad[j*8 +: 8], rx);
      u_host.close_f();
      chk(got_addr, ad, "mem_addr");
      u_host.open_f();
      u_host.xfer(8'h03, rx);
      for (int j = 3; j >= 0; j--)
        if (bv[k][7] || j < 3) u_host.xfer(~ad[j*8 +: 8], rx);
      u_host.close_f();
      chk(got_addr, bv[k][7] ? ~ad : {1'b0, bv[k][6:0], ~ad[23:0]},
          "mem_addr");
      ad = ad + 32'h0101_0101;
    end
    // Soft reset from the 4-byte mode
    u_host.open_f();
    u_host.xfer(8'hf0, rx);
    u_host.close_f();
    chk(n_soft, 1, "soft_reset");
    chk(addr4_mode, 1'b0, "addr4_mode");
    cmd_rd(8'h16, rx);
    chk(rx, 8'h00, "bank");
    // Hardware reset leaves 4-byte mode
    bank_wr(8'h80);
    chk(addr4_mode, 1'b1, "addr4_mode");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(addr4_mode, 1'b0, "addr4_mode");
    foreach (sv[k]) begin
      status2 <= sv[k];
      cmd_rd(8'h07, rx);
      chk(rx & 8'h80, sv[k] & 8'h80, "erase_size_option");
      chk(rx, sv[k], "detect");
      chk(so_oe_n, 1'b1, "so_oe_n");
    end
    tbl_chk();
    finish_test();
  end
endmodule
